// file: hw/pcf_check.sv
// Settings checker: clamps reserved codes and flags bad settings
`timescale 1ns/100ps
`default_nettype none
module pcf_check #(
   parameter logic [2:0] L1_LAT = 3'h0,
   parameter logic [5:0] DC2_FLAGS = 6'h00,
   parameter logic [1:0] OBFF = 2'h0,
   parameter logic [7:0] MSI_NEXT = 8'h00,
   parameter logic [2:0] MMC = 3'h0,
   parameter logic [7:0] MSIX_NEXT = 8'h00,
   parameter logic [2:0] PBA_BIR = 3'h0,
   parameter logic MSIX_ON = 1'b1
) (
   // Control
   input wire logic clamp_en,
   // Image
   pcf_img_if.drv img
);
   always_comb begin
      img.l1_lat = L1_LAT;
      img.dc2_flags = DC2_FLAGS;
      img.msi_next = MSI_NEXT;
      img.msix_next = MSIX_NEXT;
      // Wake-based flush hints cannot be honoured
      img.obff = (clamp_en && OBFF[1]) ? pcf_pkg::OBFF_NONE : OBFF;
      // Reserved vector codes fold to the 32-vector ceiling
      img.mmc = (clamp_en && MMC > pcf_pkg::MMC_MAX) ?
         pcf_pkg::MMC_MAX : MMC;
      img.pba_bir = (clamp_en && !MSIX_ON) ? pcf_pkg::BIR_OFF : PBA_BIR;
      img.err = {DC2_FLAGS[0],
                 (!MSIX_ON && PBA_BIR != pcf_pkg::BIR_OFF),
                 (MMC > pcf_pkg::MMC_MAX),
                 OBFF[1]};
   end
endmodule
`default_nettype wire

// file: hw/pcf_field_image.sv
// Top of the capability field image register bank
`timescale 1ns/100ps
`default_nettype none
module pcf_field_image #(
   parameter logic [2:0] L1_EXIT_LAT_SEP_8GT = 3'h0,
   parameter logic completion_timeout_off_capable = 1'b0,
   parameter logic ATOMIC32_COMPLETER = 1'b0,
   parameter logic ATOMIC64_COMPLETER = 1'b0,
   parameter logic CAS128_COMPLETER = 1'b0,
   parameter logic latency_tolerance_report_capable = 1'b0,
   parameter logic TPH_COMPLETER = 1'b0,
   parameter logic [1:0] buffer_flush_hint_capability = 2'h0,
   parameter logic [7:0] msi_following_capability_pointer = 8'h00,
   parameter logic [2:0] msi_vector_request_code = 3'h0,
   parameter logic [7:0] msix_following_capability_pointer = 8'h00,
   parameter logic [2:0] msix_pending_array_bar_select = 3'h0,
   parameter logic MSIX_ENABLED = 1'b1
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // Register port
   input wire logic [pcf_pkg::ADDR_W-1:0] addr,
   input wire logic [pcf_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [pcf_pkg::DATA_W-1:0] rd_data,
   // Status
   output logic image_live
);

   // ------------------------------------------------------------
   // Settings bundle
   // ------------------------------------------------------------
   // Flag order, low to high: timeout-off, atomic32, atomic64,
   // cas128, latency reporting, TPH completer
   localparam logic [5:0] DC2_FLAGS = {
      TPH_COMPLETER,
      latency_tolerance_report_capable,
      CAS128_COMPLETER,
      ATOMIC64_COMPLETER,
      ATOMIC32_COMPLETER,
      completion_timeout_off_capable
   };

   pcf_img_if img ();

   logic [pcf_pkg::CTRL_W-1:0] ctrl_r;
   logic [pcf_pkg::ERR_W-1:0] err_r;
   logic [pcf_pkg::ERR_W-1:0] err_nxt;
   pcf_pkg::pcf_state_t state_r;
   pcf_pkg::pcf_state_t state_nxt;
   logic refresh;
   logic err_clr_hit;
   logic [pcf_pkg::DATA_W-1:0] rd_word;

   logic [pcf_pkg::LAT_W-1:0] l1_lat_q;
   logic [5:0] dc2_q;
   logic [pcf_pkg::OBFF_W-1:0] obff_q;
   logic [pcf_pkg::PTR_W-1:0] msi_next_q;
   logic [pcf_pkg::MMC_W-1:0] mmc_q;
   logic [pcf_pkg::PTR_W-1:0] msix_next_q;
   logic [pcf_pkg::BIR_W-1:0] bir_q;

   // ------------------------------------------------------------
   // Settings checker
   // ------------------------------------------------------------
   pcf_check #(
      .L1_LAT(L1_EXIT_LAT_SEP_8GT),
      .DC2_FLAGS(DC2_FLAGS),
      .OBFF(buffer_flush_hint_capability),
      .MSI_NEXT(msi_following_capability_pointer),
      .MMC(msi_vector_request_code),
      .MSIX_NEXT(msix_following_capability_pointer),
      .PBA_BIR(msix_pending_array_bar_select),
      .MSIX_ON(MSIX_ENABLED)
   ) u_check (
      .clamp_en(ctrl_r[pcf_pkg::CTRL_CLAMP_EN]),
      .img(img.drv)
   );

   // ------------------------------------------------------------
   // Field holders
   // ------------------------------------------------------------
   // Reset values are the raw settings, so every field is valid
   // from reset onward with no boot delay
   pcf_hold #(
      .W(pcf_pkg::LAT_W),
      .RST_VAL(L1_EXIT_LAT_SEP_8GT)
   ) u_l1_lat (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .d(img.l1_lat),
      .q(l1_lat_q)
   );

   pcf_hold #(
      .W(6),
      .RST_VAL(DC2_FLAGS)
   ) u_dc2 (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .d(img.dc2_flags),
      .q(dc2_q)
   );

   pcf_hold #(
      .W(pcf_pkg::OBFF_W),
      .RST_VAL(buffer_flush_hint_capability)
   ) u_obff (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .d(img.obff),
      .q(obff_q)
   );

   pcf_hold #(
      .W(pcf_pkg::PTR_W),
      .RST_VAL(msi_following_capability_pointer)
   ) u_msi_next (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .d(img.msi_next),
      .q(msi_next_q)
   );

   pcf_hold #(
      .W(pcf_pkg::MMC_W),
      .RST_VAL(msi_vector_request_code)
   ) u_mmc (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .d(img.mmc),
      .q(mmc_q)
   );

   pcf_hold #(
      .W(pcf_pkg::PTR_W),
      .RST_VAL(msix_following_capability_pointer)
   ) u_msix_next (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .d(img.msix_next),
      .q(msix_next_q)
   );

   pcf_hold #(
      .W(pcf_pkg::BIR_W),
      .RST_VAL(msix_pending_array_bar_select)
   ) u_bir (
      .mclk(mclk),
      .rst_n(rst_n),
      .ce(ce),
      .d(img.pba_bir),
      .q(bir_q)
   );

   // ------------------------------------------------------------
   // Control register
   // ------------------------------------------------------------
   // Only the control and status words are writable; capability words drop writes
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_r <= pcf_pkg::CTRL_RST;
      end else if (ce && wr_en && addr == pcf_pkg::OFS_CTRL) begin
         ctrl_r <= wr_data[pcf_pkg::CTRL_W-1:0];
      end
   end

   assign refresh = wr_en && addr == pcf_pkg::OFS_CTRL &&
      wr_data[pcf_pkg::CTRL_REFRESH];

   // ------------------------------------------------------------
   // Check sequencer
   // ------------------------------------------------------------
   // One scan cycle after reset and after each refresh request made in the live state
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         pcf_pkg::PCF_BOOT: begin
            state_nxt = pcf_pkg::PCF_SCAN;
         end
         pcf_pkg::PCF_SCAN: begin
            state_nxt = pcf_pkg::PCF_LIVE;
         end
         pcf_pkg::PCF_LIVE: begin
            if (refresh) begin
               state_nxt = pcf_pkg::PCF_SCAN;
            end
         end
         default: begin
            state_nxt = pcf_pkg::PCF_BOOT;
         end
      endcase
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= pcf_pkg::PCF_BOOT;
      end else if (ce) begin
         state_r <= state_nxt;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         image_live <= 1'b0;
      end else if (ce) begin
         image_live <= (state_nxt == pcf_pkg::PCF_LIVE);
      end
   end

   // ------------------------------------------------------------
   // Sticky setting errors
   // ------------------------------------------------------------
   // Write one to clear; a scan hit in the same cycle wins
   assign err_clr_hit = wr_en && addr == pcf_pkg::OFS_STATUS;

   always_comb begin
      err_nxt = err_r;
      if (err_clr_hit) begin
         err_nxt = err_r &
            ~wr_data[pcf_pkg::STAT_ERR_LSB +: pcf_pkg::ERR_W];
      end
      if (state_r == pcf_pkg::PCF_SCAN &&
          ctrl_r[pcf_pkg::CTRL_CHECK_EN]) begin
         err_nxt = err_nxt | img.err;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         err_r <= '0;
      end else if (ce) begin
         err_r <= err_nxt;
      end
   end

   // ------------------------------------------------------------
   // Read word assembly
   // ------------------------------------------------------------
   always_comb begin
      rd_word = '0;
      if (addr == pcf_pkg::OFS_LINK_CAP) begin
         rd_word[pcf_pkg::LCAP_L1_LSB +: pcf_pkg::LAT_W] = l1_lat_q;
      end else if (addr == pcf_pkg::OFS_DEV_CAP2) begin
         rd_word[pcf_pkg::DC2_CTO_OFF] = dc2_q[0];
         rd_word[pcf_pkg::DC2_ATOM32] = dc2_q[1];
         rd_word[pcf_pkg::DC2_ATOM64] = dc2_q[2];
         rd_word[pcf_pkg::DC2_CAS128] = dc2_q[3];
         rd_word[pcf_pkg::DC2_LTR] = dc2_q[4];
         rd_word[pcf_pkg::DC2_TPH] = dc2_q[5];
         rd_word[pcf_pkg::DC2_OBFF_LSB +: pcf_pkg::OBFF_W] = obff_q;
      end else if (addr == pcf_pkg::OFS_MSI_HDR) begin
         rd_word[pcf_pkg::CAP_ID_LSB +: pcf_pkg::PTR_W] =
            pcf_pkg::MSI_CAP_ID;
         rd_word[pcf_pkg::PTR_LSB +: pcf_pkg::PTR_W] = msi_next_q;
         rd_word[pcf_pkg::MMC_LSB +: pcf_pkg::MMC_W] = mmc_q;
      end else if (addr == pcf_pkg::OFS_MSIX_HDR) begin
         rd_word[pcf_pkg::CAP_ID_LSB +: pcf_pkg::PTR_W] =
            pcf_pkg::MSIX_CAP_ID;
         rd_word[pcf_pkg::PTR_LSB +: pcf_pkg::PTR_W] = msix_next_q;
      end else if (addr == pcf_pkg::OFS_MSIX_PBA) begin
         rd_word[pcf_pkg::BIR_LSB +: pcf_pkg::BIR_W] = bir_q;
      end else if (addr == pcf_pkg::OFS_CTRL) begin
         rd_word[pcf_pkg::CTRL_W-1:0] = ctrl_r;
      end else if (addr == pcf_pkg::OFS_STATUS) begin
         rd_word[1:0] = state_r;
         rd_word[pcf_pkg::STAT_LIVE] = (state_r == pcf_pkg::PCF_LIVE);
         rd_word[pcf_pkg::STAT_ERR_LSB +: pcf_pkg::ERR_W] = err_r;
      end
   end

   // ------------------------------------------------------------
   // Read data register
   // ------------------------------------------------------------
   // Data stands in the cycle after a strobe taken with ce high; zero after an enabled idle cycle; held while ce is low
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         rd_data <= '0;
      end else if (ce) begin
         rd_data <= rd_en ? rd_word : '0;
      end
   end

endmodule
`default_nettype wire

// file: hw/pcf_hold.sv
// Read-only field holder, loaded from its settled image value
`timescale 1ns/100ps
`default_nettype none
module pcf_hold #(
   parameter int W = 3,
   parameter logic [W-1:0] RST_VAL = '0
) (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst_n,
   input wire logic ce,
   // Field
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   // Reset loads the build-time value, so the field is valid at once
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         q <= RST_VAL;
      end else if (ce) begin
         q <= d;
      end
   end
endmodule
`default_nettype wire

// file: hw/pcf_img_if.sv
// Capability image bundle passed from the checker to the top
`timescale 1ns/100ps
`default_nettype none
interface pcf_img_if;
   logic [pcf_pkg::LAT_W-1:0] l1_lat;
   logic [5:0] dc2_flags;
   logic [pcf_pkg::OBFF_W-1:0] obff;
   logic [pcf_pkg::PTR_W-1:0] msi_next;
   logic [pcf_pkg::MMC_W-1:0] mmc;
   logic [pcf_pkg::PTR_W-1:0] msix_next;
   logic [pcf_pkg::BIR_W-1:0] pba_bir;
   logic [pcf_pkg::ERR_W-1:0] err;
   modport drv (output l1_lat, dc2_flags, obff, msi_next, mmc,
      msix_next, pba_bir, err);
   modport use_side (input l1_lat, dc2_flags, obff, msi_next, mmc,
      msix_next, pba_bir, err);
endinterface
`default_nettype wire

// file: hw/pcf_pkg.sv
// Shared constants and types of the capability field image block
package pcf_pkg;

   // ------------------------------------------------------------
   // Register bus
   // ------------------------------------------------------------
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;

   // ------------------------------------------------------------
   // Register offsets (byte addresses)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_LINK_CAP = 8'h00;
   localparam logic [7:0] OFS_DEV_CAP2 = 8'h04;
   localparam logic [7:0] OFS_MSI_HDR = 8'h08;
   localparam logic [7:0] OFS_MSIX_HDR = 8'h0C;
   localparam logic [7:0] OFS_MSIX_PBA = 8'h10;
   localparam logic [7:0] OFS_CTRL = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;

   // ------------------------------------------------------------
   // Field layouts
   // ------------------------------------------------------------
   localparam int LAT_W = 3;
   localparam int LCAP_L1_LSB = 15;
   localparam int DC2_CTO_OFF = 4;
   localparam int DC2_ATOM32 = 7;
   localparam int DC2_ATOM64 = 8;
   localparam int DC2_CAS128 = 9;
   localparam int DC2_LTR = 11;
   localparam int DC2_TPH = 12;
   localparam int OBFF_W = 2;
   localparam int DC2_OBFF_LSB = 18;
   localparam int CAP_ID_LSB = 0;
   localparam int PTR_W = 8;
   localparam int PTR_LSB = 8;
   localparam int MMC_W = 3;
   localparam int MMC_LSB = 17;
   localparam int BIR_W = 3;
   localparam int BIR_LSB = 0;
   localparam int ERR_W = 4;

   // ------------------------------------------------------------
   // Codes and reset values
   // ------------------------------------------------------------
   localparam logic [7:0] MSI_CAP_ID = 8'h05;
   localparam logic [7:0] MSIX_CAP_ID = 8'h11;
   localparam logic [1:0] OBFF_NONE = 2'h0;
   localparam logic [2:0] MMC_MAX = 3'h5;
   localparam logic [2:0] BIR_OFF = 3'h0;
   localparam int CTRL_W = 2;
   localparam int CTRL_CHECK_EN = 0;
   localparam int CTRL_CLAMP_EN = 1;
   localparam int CTRL_REFRESH = 2;
   localparam logic [1:0] CTRL_RST = 2'h1;
   localparam int STAT_LIVE = 2;
   localparam int STAT_ERR_LSB = 8;

   typedef enum logic [1:0] {
      PCF_BOOT = 2'h0,
      PCF_SCAN = 2'h1,
      PCF_LIVE = 2'h3
   } pcf_state_t;

endpackage

// file: sim/pcf_field_image_asserts.sv
// Port-level assertions for the capability field image block
`timescale 1ns/100ps
`default_nettype none
module pcf_field_image_asserts #(
   parameter logic [2:0] L1 = 3'h0,
   parameter logic [5:0] FL = 6'h00,
   parameter logic [1:0] FH = 2'h0,
   parameter logic [7:0] MSI_NX = 8'h00,
   parameter logic [2:0] MMC = 3'h0,
   parameter logic [7:0] MSIX_NX = 8'h00,
   parameter logic [2:0] BIR = 3'h0
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst_n,
   // Register port
   input wire logic ce,
   input wire logic [pcf_pkg::ADDR_W-1:0] addr,
   input wire logic [pcf_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [pcf_pkg::DATA_W-1:0] rd_data,
   input wire logic image_live
);
   // -------------------------------------------------------------
   // Read answers against the build settings
   // -------------------------------------------------------------
   // Limitation: only legal settings, clamping would alter 3 fields
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_n);

   a_l1_latency: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_LINK_CAP |=> rd_data[17:15] == L1)
      else $error("L1 exit latency field wrong");
   a_cto_off_bit: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_DEV_CAP2 |=> rd_data[4] == FL[0])
      else $error("timeout off bit wrong");
   a_atomic_bits: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_DEV_CAP2 |=> rd_data[9:7] == FL[3:1])
      else $error("atomic completer bits wrong");
   a_ltr_tph_bits: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_DEV_CAP2
      |=> rd_data[12:11] == FL[5:4])
      else $error("LTR or TPH bit wrong");
   a_flush_hint: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_DEV_CAP2 |=> rd_data[19:18] == FH)
      else $error("flush hint field wrong");
   a_msi_header: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_MSI_HDR
      |=> {rd_data[19:17], rd_data[15:8]} == {MMC, MSI_NX})
      else $error("MSI header fields wrong");
   a_msix_next: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_MSIX_HDR |=> rd_data[15:8] == MSIX_NX)
      else $error("MSI-X next pointer wrong");
   a_pba_select: assert property (
      ce && rd_en && addr == pcf_pkg::OFS_MSIX_PBA |=> rd_data[2:0] == BIR)
      else $error("pending array BAR select wrong");
   a_rd_idle_zero: assert property (
      ce && !rd_en |=> rd_data == '0)
      else $error("read data not zero outside a read");
endmodule

bind pcf_field_image pcf_field_image_asserts #(
   .L1(L1_EXIT_LAT_SEP_8GT),
   .FL({TPH_COMPLETER, latency_tolerance_report_capable, CAS128_COMPLETER,
      ATOMIC64_COMPLETER, ATOMIC32_COMPLETER, completion_timeout_off_capable}),
   .FH(buffer_flush_hint_capability),
   .MSI_NX(msi_following_capability_pointer),
   .MMC(msi_vector_request_code),
   .MSIX_NX(msix_following_capability_pointer),
   .BIR(msix_pending_array_bar_select)
) u_chk (
   .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
   .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .image_live(image_live)
);
`default_nettype wire

// file: sim/tb_top.sv
// Self-checking testbench for the capability field image block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
   // -------------------------------------------------------------
   // Signals and expected words
   // -------------------------------------------------------------
   logic mclk = 1'b0;
   logic rst_n = 1'b0;
   logic ce = 1'b1;
   logic [7:0] addr = 8'h00;
   logic [31:0] wr_data = 32'h00000000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [31:0] rd_data;
   logic image_live;
   int fails = 0;
   int n_compared = 0;
   // Latency 5 in [17:15]
   localparam logic [31:0] W_LINK = 32'h00028000;
   // Bits 4, 7, 8, 9, 11, 12 and flush code 01b in [19:18]
   localparam logic [31:0] W_DC2 = 32'h00041B90;
   // Code 5 in [19:17], next 9Ch, capability code 05h
   localparam logic [31:0] W_MSI = 32'h000A9C05;
   // Last in list: next pointer 00h, capability code 11h
   localparam logic [31:0] W_MSIX = 32'h00000011;
   localparam logic [31:0] W_PBA = 32'h00000002;
   // Build settings; all are legal codes, so the clamp has nothing to fold
   localparam logic [2:0] S_LAT = 3'h5;
   localparam logic [5:0] S_FLAGS = 6'h3F; // sets all six flag bits
   localparam logic [1:0] S_HINT = 2'h1; // message-only code
   localparam logic [7:0] S_MSI_NX = 8'h9C;
   localparam logic [2:0] S_VEC = 3'h5;
   localparam logic [7:0] S_MSIX_NX = 8'h00;
   localparam logic [2:0] S_BIR = 3'h2;
   localparam logic S_MSIX_ON = 1'b1; // MSI-X on, select may be set

   always #20 mclk = ~mclk;

   pcf_field_image #(
      .L1_EXIT_LAT_SEP_8GT(S_LAT),
      .completion_timeout_off_capable(S_FLAGS[0]),
      .ATOMIC32_COMPLETER(S_FLAGS[1]), .ATOMIC64_COMPLETER(S_FLAGS[2]),
      .CAS128_COMPLETER(S_FLAGS[3]),
      .latency_tolerance_report_capable(S_FLAGS[4]),
      .TPH_COMPLETER(S_FLAGS[5]), .buffer_flush_hint_capability(S_HINT),
      .msi_following_capability_pointer(S_MSI_NX),
      .msi_vector_request_code(S_VEC),
      .msix_following_capability_pointer(S_MSIX_NX),
      .msix_pending_array_bar_select(S_BIR), .MSIX_ENABLED(S_MSIX_ON)
   ) u_dut (
      .mclk(mclk), .rst_n(rst_n), .ce(ce), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
      .image_live(image_live)
   );

   // -------------------------------------------------------------
   // Bus tasks; rd and wr leave their strobe up so reads run back to back
   // -------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         fails++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      addr <= a;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      @(posedge mclk);
      #1;
      chk(rd_data, exp);
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      addr <= a;
      wr_data <= d;
      rd_en <= 1'b0;
      wr_en <= 1'b1;
      @(posedge mclk);
      #1;
   endtask

   task automatic idle();
      rd_en <= 1'b0;
      wr_en <= 1'b0;
      @(posedge mclk);
      #1;
      chk(rd_data, 32'h00000000);
   endtask

   task automatic read_image();
      rd(pcf_pkg::OFS_LINK_CAP, W_LINK);
      rd(pcf_pkg::OFS_DEV_CAP2, W_DC2);
      rd(pcf_pkg::OFS_MSI_HDR, W_MSI);
      rd(pcf_pkg::OFS_MSIX_HDR, W_MSIX);
      rd(pcf_pkg::OFS_MSIX_PBA, W_PBA);
      idle();
   endtask

   // -------------------------------------------------------------
   // Scenarios
   // -------------------------------------------------------------
   // Fields are valid from the first edge after reset, not after the scan
   task automatic t_from_reset();
      chk(32'(image_live), 32'h00000000);
      read_image();
      chk(32'(image_live), 32'h00000001);
   endtask

   // Writes of all ones and all zeros to every capability word are ignored
   task automatic t_write_ignored();
      for (int i = 0; i < 5; i++) begin
         wr(8'(4 * i), 32'hFFFFFFFF);
      end
      read_image();
      for (int i = 0; i < 5; i++) begin
         wr(8'(4 * i), 32'h00000000);
      end
      read_image();
   endtask

   // Legal settings must pass the clamp untouched
   task automatic t_clamp_legal();
      wr(pcf_pkg::OFS_CTRL, 32'h00000003);
      idle();
      idle();
      read_image();
   endtask

   // Status shows each scan; a scan hit beats a clear in the same cycle
   task automatic t_status_regs();
      rd(pcf_pkg::OFS_CTRL, 32'h00000003);
      rd(pcf_pkg::OFS_STATUS, 32'h00000807);
      wr(pcf_pkg::OFS_STATUS, 32'h00000800);
      rd(pcf_pkg::OFS_STATUS, 32'h00000007);
      wr(pcf_pkg::OFS_CTRL, 32'h00000007);
      chk(32'(image_live), 32'h00000000);
      rd(pcf_pkg::OFS_STATUS, 32'h00000001);
      chk(32'(image_live), 32'h00000001);
      rd(pcf_pkg::OFS_STATUS, 32'h00000807);
      wr(pcf_pkg::OFS_CTRL, 32'h00000007);
      wr(pcf_pkg::OFS_STATUS, 32'h00000800);
      rd(pcf_pkg::OFS_STATUS, 32'h00000807);
      wr(pcf_pkg::OFS_STATUS, 32'h00000800);
      wr(pcf_pkg::OFS_CTRL, 32'h00000006);
      rd(pcf_pkg::OFS_STATUS, 32'h00000001);
      rd(pcf_pkg::OFS_STATUS, 32'h00000007);
      wr(pcf_pkg::OFS_CTRL, 32'h00000003);
      rd(pcf_pkg::OFS_CTRL, 32'h00000003);
      idle();
   endtask

   // A read while the clock enable is low must not be taken
   task automatic t_ce_low();
      ce <= 1'b0;
      rd(pcf_pkg::OFS_DEV_CAP2, 32'h00000000);
      ce <= 1'b1;
      rd_en <= 1'b0;
      @(posedge mclk);
      #1;
      rd(8'hFC, 32'h00000000);
      idle();
   endtask

   // -------------------------------------------------------------
   // Ending and watchdog
   // -------------------------------------------------------------
   task automatic stop_test();
      $display("compares %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   initial begin
      #20000;
      fails++;
      stop_test();
   end

   initial begin
      repeat (2) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      @(posedge mclk);
      #1;
      t_from_reset();
      t_write_ignored();
      t_clamp_legal();
      t_status_regs();
      t_ce_low();
      stop_test();
   end
endmodule
`default_nettype wire
